// file: hdl/pbm_pkg.sv
// Constants and types for the basic mode control register block
`default_nettype none
package pbm_pkg;
  // Register addresses on the serial management interface
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_RX_ERR_COUNT = 5'h14;

  // Control register field positions
  localparam int CTL_RESET = 15;
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_SPEED = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_ISOLATE = 10;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;
  localparam logic [15:0] CTL_RESET_VALUE = 16'h0000;

  // Status register field positions and fixed ability bits
  localparam int STS_AN_COMPLETE = 5;
  localparam int STS_REMOTE_FAULT = 4;
  localparam int STS_LINK = 2;
  localparam int STS_JABBER = 1;
  localparam logic [15:0] STS_FIXED_VALUE = 16'h7848;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOOPBACK_DEAD_US = 500;
  localparam int LOOPBACK_DEAD_CYCLES = (LOOPBACK_DEAD_US * 1000) / CLK_PERIOD_NS;

  // Management frame fields
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [4:0] MDIO_HDR_LAST = 5'h0b;
  localparam logic [4:0] MDIO_DATA_LAST = 5'h0f;

  typedef enum logic [3:0] {
    MDIO_IDLE = 4'h1,
    MDIO_HDR = 4'h2,
    MDIO_TURN = 4'h4,
    MDIO_DATA = 4'h8
  } pbm_mdio_state_t;
endpackage : pbm_pkg
`default_nettype wire

// file: hdl/pbm_mdio_slave.sv
// Serial management frame slave: decodes read and write frames
`default_nettype none
module pbm_mdio_slave (
  // Clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Own address
  input wire logic [4:0] phy_addr_in,
  // Register access
  output logic [4:0] reg_addr_out,
  output logic rd_strobe_out,
  input wire logic [15:0] rd_data_in,
  output logic wr_strobe_out,
  output logic [15:0] wr_data_out
);
  pbm_pkg::pbm_mdio_state_t state_q;
  logic mdc_q;
  logic [4:0] cnt_q;
  logic [15:0] shift_q;
  logic is_read_q;
  logic mine_q;
  logic rise;
  logic [11:0] hdr;

  assign rise = mdc_in & ~mdc_q;
  assign hdr = {shift_q[10:0], mdio_in};

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mdc_q <= 1'b0;
      state_q <= pbm_pkg::MDIO_IDLE;
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      is_read_q <= 1'b0;
      mine_q <= 1'b0;
      reg_addr_out <= 5'h00;
      rd_strobe_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      wr_data_out <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else if (ce_in) begin
      mdc_q <= mdc_in;
      rd_strobe_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      // Read data is taken together with the strobe, before clear-on-read acts
      if (rd_strobe_out) begin
        shift_q <= rd_data_in;
      end
      if (rise) begin
        unique case (state_q)
          pbm_pkg::MDIO_IDLE: begin
            shift_q <= {shift_q[14:0], mdio_in};
            // Start pattern 01 after at least one idle one
            if (shift_q[1:0] == 2'h2 && mdio_in) begin
              state_q <= pbm_pkg::MDIO_HDR;
              cnt_q <= 5'h00;
            end
          end
          pbm_pkg::MDIO_HDR: begin
            shift_q <= {shift_q[14:0], mdio_in};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == pbm_pkg::MDIO_HDR_LAST) begin
              cnt_q <= 5'h00;
              reg_addr_out <= hdr[4:0];
              mine_q <= (hdr[9:5] == phy_addr_in);
              is_read_q <= (hdr[11:10] == pbm_pkg::MDIO_OP_READ);
              if (hdr[11:10] == pbm_pkg::MDIO_OP_READ || hdr[11:10] == pbm_pkg::MDIO_OP_WRITE) begin
                state_q <= pbm_pkg::MDIO_TURN;
                rd_strobe_out <= (hdr[11:10] == pbm_pkg::MDIO_OP_READ) && (hdr[9:5] == phy_addr_in);
              end else begin
                state_q <= pbm_pkg::MDIO_IDLE;
              end
            end
          end
          pbm_pkg::MDIO_TURN: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h00) begin
              // Second turnaround bit is driven low by us on reads
              mdio_oe_out <= is_read_q & mine_q;
              mdio_out <= 1'b0;
            end else begin
              cnt_q <= 5'h00;
              state_q <= pbm_pkg::MDIO_DATA;
              if (is_read_q) begin
                mdio_out <= shift_q[15];
                shift_q <= {shift_q[14:0], 1'b0};
              end
            end
          end
          pbm_pkg::MDIO_DATA: begin
            cnt_q <= cnt_q + 5'h01;
            if (is_read_q) begin
              mdio_out <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'b0};
            end else begin
              shift_q <= {shift_q[14:0], mdio_in};
            end
            if (cnt_q == pbm_pkg::MDIO_DATA_LAST) begin
              state_q <= pbm_pkg::MDIO_IDLE;
              mdio_oe_out <= 1'b0;
              mdio_out <= 1'b0;
              shift_q <= 16'h0000;
              if (!is_read_q) begin
                wr_data_out <= {shift_q[14:0], mdio_in};
                wr_strobe_out <= mine_q;
              end
            end
          end
        endcase
      end
    end
  end
endmodule : pbm_mdio_slave
`default_nettype wire

// file: hdl/pbm_basic_mode_control.sv
// Basic mode control register, port control and MII gating of one port
// What this block does
// - Writing the top control bit starts a soft reset; bit reads one until done.
// - Soft reset reloads configuration from the straps like a hardware reset.
// - Loopback bit set routes MII transmit data back onto MII receive.
// - After loopback is enabled, receive data may be invalid for about 500 us.
// - With negotiation off, speed bit picks 100 Mb/s or 10 Mb/s; strap reset value.
// - Negotiation enable bit takes its reset value from a strap.
// - Fiber mode forces the negotiation enable bit to zero at reset.
// - While negotiation is on, forced speed and duplex bits are ignored.
// - While negotiation is off, forced speed and duplex bits alone set the mode.
// - Power down bit powers the port down; only registers stay alive.
// - Effective power down is the bit OR the active-low external pin.
// - External power-down pin asserted sets the power down bit.
// - Isolate bit disconnects the port from MII; management still works.
// - Writing restart starts negotiation; ignored while negotiation is off.
// - Restart bit reads one until negotiation has begun, then self-clears.
// - Writing zero to restart leaves a running negotiation undisturbed.
// - With negotiation off, duplex bit picks full or half; strap reset value.
// - Collision test raises COL within 512 bit times of TX_EN rising.
// - Collision test drops COL within 4 bit times of TX_EN falling.
// - Low seven control bits ignore writes and read zero.
// - Latching status bits hold their captured event until the register is read.
// - Clear-on-read bits return their value, then reset to zero; an error in the read cycle leaves the count at one.
// - Latched-low link bit is set again only after good link and a read.
`default_nettype none
module pbm_basic_mode_control #(
  parameter int LOOPBACK_DEAD_CYCLES = pbm_pkg::LOOPBACK_DEAD_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Serial management
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Straps and pins
  input wire logic [4:0] strap_phy_addr_in,
  input wire logic strap_speed_100_in,
  input wire logic strap_full_duplex_in,
  input wire logic strap_an_enable_in,
  input wire logic fiber_mode_enable_in,
  input wire logic external_power_down_pin_n_in,
  // Negotiation engine and line status
  input wire logic an_started_in,
  input wire logic an_speed_100_in,
  input wire logic an_full_duplex_in,
  input wire logic an_complete_in,
  input wire logic link_up_in,
  input wire logic remote_fault_in,
  input wire logic jabber_in,
  input wire logic rx_error_in,
  // MII from the MAC
  input wire logic tx_en_in,
  input wire logic [3:0] txd_in,
  // Media side receive
  input wire logic media_rx_dv_in,
  input wire logic [3:0] media_rxd_in,
  input wire logic media_crs_in,
  input wire logic media_col_in,
  // MII to the MAC
  output logic rx_dv_out,
  output logic [3:0] rxd_out,
  output logic crs_out,
  output logic col_out,
  output logic mii_oe_out,
  // Media side transmit
  output logic media_tx_en_out,
  output logic [3:0] media_txd_out,
  // Port control
  output logic port_reset_out,
  output logic power_down_out,
  output logic speed_100_out,
  output logic full_duplex_out,
  output logic an_enable_out,
  output logic an_restart_out
);
  logic [4:0] reg_addr;
  logic rd_strobe;
  logic wr_strobe;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [4:0] phy_addr_q;
  logic strap_load_q;
  logic soft_rst_q;
  logic [5:0] rst_cnt_q;
  logic rst_done;
  logic loopback_q, speed_q, an_en_q, pwrdn_q, isolate_q, restart_q, duplex_q, coltest_q;
  logic [13:0] dead_cnt_q;
  logic link_ll_q, rfault_lh_q, jabber_lh_q;
  logic [15:0] rxerr_cnt_q;
  logic ctl_wr, sts_rd, cnt_rd, pd_eff;

  pbm_mdio_slave u_mdio (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .mdc_in(mdc_in),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out),
    .phy_addr_in(phy_addr_q),
    .reg_addr_out(reg_addr),
    .rd_strobe_out(rd_strobe),
    .rd_data_in(rd_data),
    .wr_strobe_out(wr_strobe),
    .wr_data_out(wr_data)
  );

  // Writes are ignored while a soft reset is running
  assign ctl_wr = wr_strobe && reg_addr == pbm_pkg::REG_CONTROL && !soft_rst_q;
  assign sts_rd = rd_strobe && reg_addr == pbm_pkg::REG_STATUS;
  assign cnt_rd = rd_strobe && reg_addr == pbm_pkg::REG_RX_ERR_COUNT;
  assign rst_done = soft_rst_q && rst_cnt_q == 6'h00;
  assign pd_eff = pwrdn_q | ~external_power_down_pin_n_in;

  // Read mux; unmapped registers read as zero
  always_comb begin
    rd_data = 16'h0000;
    if (reg_addr == pbm_pkg::REG_CONTROL) begin
      rd_data[pbm_pkg::CTL_RESET] = soft_rst_q;
      rd_data[pbm_pkg::CTL_LOOPBACK] = loopback_q;
      rd_data[pbm_pkg::CTL_SPEED] = speed_q;
      rd_data[pbm_pkg::CTL_AN_ENABLE] = an_en_q;
      rd_data[pbm_pkg::CTL_POWER_DOWN] = pwrdn_q;
      rd_data[pbm_pkg::CTL_ISOLATE] = isolate_q;
      rd_data[pbm_pkg::CTL_RESTART] = restart_q;
      rd_data[pbm_pkg::CTL_DUPLEX] = duplex_q;
      rd_data[pbm_pkg::CTL_COL_TEST] = coltest_q;
    end else if (reg_addr == pbm_pkg::REG_STATUS) begin
      rd_data = pbm_pkg::STS_FIXED_VALUE;
      rd_data[pbm_pkg::STS_AN_COMPLETE] = an_complete_in;
      rd_data[pbm_pkg::STS_REMOTE_FAULT] = rfault_lh_q;
      rd_data[pbm_pkg::STS_LINK] = link_ll_q;
      rd_data[pbm_pkg::STS_JABBER] = jabber_lh_q;
    end else if (reg_addr == pbm_pkg::REG_RX_ERR_COUNT) begin
      rd_data = rxerr_cnt_q;
    end
  end

  // Strap capture after hardware reset release and at soft reset end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_load_q <= 1'b1;
      phy_addr_q <= 5'h00;
    end else if (ce_in) begin
      strap_load_q <= 1'b0;
      if (strap_load_q || rst_done) begin
        phy_addr_q <= strap_phy_addr_in;
      end
    end
  end

  // Soft reset sequencer
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      soft_rst_q <= 1'b0;
      rst_cnt_q <= 6'h00;
    end else if (ce_in) begin
      if (ctl_wr && wr_data[pbm_pkg::CTL_RESET]) begin
        soft_rst_q <= 1'b1;
        rst_cnt_q <= 6'(pbm_pkg::SOFT_RESET_CYCLES - 1);
      end else if (rst_done) begin
        soft_rst_q <= 1'b0;
      end else if (soft_rst_q) begin
        rst_cnt_q <= rst_cnt_q - 6'h01;
      end
    end
  end

  // Control bits
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      loopback_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_LOOPBACK];
      speed_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_SPEED];
      an_en_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_AN_ENABLE];
      pwrdn_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_POWER_DOWN];
      isolate_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_ISOLATE];
      duplex_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_DUPLEX];
      coltest_q <= pbm_pkg::CTL_RESET_VALUE[pbm_pkg::CTL_COL_TEST];
    end else if (ce_in) begin
      if (strap_load_q || rst_done) begin
        loopback_q <= 1'b0;
        speed_q <= strap_speed_100_in;
        an_en_q <= strap_an_enable_in & ~fiber_mode_enable_in;
        pwrdn_q <= 1'b0;
        isolate_q <= 1'b0;
        duplex_q <= strap_full_duplex_in;
        coltest_q <= 1'b0;
      end else if (ctl_wr) begin
        loopback_q <= wr_data[pbm_pkg::CTL_LOOPBACK];
        speed_q <= wr_data[pbm_pkg::CTL_SPEED];
        an_en_q <= wr_data[pbm_pkg::CTL_AN_ENABLE];
        pwrdn_q <= wr_data[pbm_pkg::CTL_POWER_DOWN];
        isolate_q <= wr_data[pbm_pkg::CTL_ISOLATE];
        duplex_q <= wr_data[pbm_pkg::CTL_DUPLEX];
        coltest_q <= wr_data[pbm_pkg::CTL_COL_TEST];
      end
      // Pin assertion wins over a write of zero
      if (!external_power_down_pin_n_in) begin
        pwrdn_q <= 1'b1;
      end
    end
  end

  // Restart request: set wins over the engine's acknowledge
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      restart_q <= 1'b0;
    end else if (ce_in) begin
      if (strap_load_q || rst_done) begin
        restart_q <= 1'b0;
      end else if (ctl_wr && !wr_data[pbm_pkg::CTL_AN_ENABLE]) begin
        restart_q <= 1'b0;
      end else if (ctl_wr && wr_data[pbm_pkg::CTL_RESTART]) begin
        restart_q <= 1'b1;
      end else if (an_started_in) begin
        restart_q <= 1'b0;
      end
    end
  end

  // Loopback dead time, started by each write that sets loopback while it is off
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dead_cnt_q <= 14'h0000;
    end else if (ce_in) begin
      if (ctl_wr && wr_data[pbm_pkg::CTL_LOOPBACK] && !loopback_q) begin
        dead_cnt_q <= 14'(LOOPBACK_DEAD_CYCLES);
      end else if (dead_cnt_q != 14'h0000) begin
        dead_cnt_q <= dead_cnt_q - 14'h0001;
      end
    end
  end

  // Latching status and clear-on-read counter; events win over the read
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_ll_q <= 1'b0;
      rfault_lh_q <= 1'b0;
      jabber_lh_q <= 1'b0;
      rxerr_cnt_q <= 16'h0000;
    end else if (ce_in) begin
      if (!link_up_in) begin
        link_ll_q <= 1'b0;
      end else if (sts_rd) begin
        link_ll_q <= 1'b1;
      end
      if (remote_fault_in) begin
        rfault_lh_q <= 1'b1;
      end else if (sts_rd) begin
        rfault_lh_q <= 1'b0;
      end
      if (jabber_in) begin
        jabber_lh_q <= 1'b1;
      end else if (sts_rd) begin
        jabber_lh_q <= 1'b0;
      end
      if (cnt_rd) begin
        rxerr_cnt_q <= {15'h0000, rx_error_in};
      end else if (rx_error_in && rxerr_cnt_q != 16'hffff) begin
        rxerr_cnt_q <= rxerr_cnt_q + 16'h0001;
      end
    end
  end

  // Port control outputs
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port_reset_out <= 1'b0;
      power_down_out <= 1'b0;
      speed_100_out <= 1'b0;
      full_duplex_out <= 1'b0;
      an_enable_out <= 1'b0;
      an_restart_out <= 1'b0;
    end else if (ce_in) begin
      port_reset_out <= soft_rst_q;
      power_down_out <= pd_eff;
      speed_100_out <= an_en_q ? an_speed_100_in : speed_q;
      full_duplex_out <= an_en_q ? an_full_duplex_in : duplex_q;
      an_enable_out <= an_en_q;
      an_restart_out <= restart_q;
    end
  end

  // MII data path; the one-cycle register delays COL by one clock, 4 bit times at 100 Mb/s
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_dv_out <= 1'b0;
      rxd_out <= 4'h0;
      crs_out <= 1'b0;
      col_out <= 1'b0;
      mii_oe_out <= 1'b0;
      media_tx_en_out <= 1'b0;
      media_txd_out <= 4'h0;
    end else if (ce_in) begin
      mii_oe_out <= ~isolate_q;
      media_tx_en_out <= tx_en_in & ~loopback_q & ~isolate_q & ~pd_eff;
      media_txd_out <= (loopback_q | isolate_q | pd_eff) ? 4'h0 : txd_in;
      if (isolate_q || pd_eff) begin
        rx_dv_out <= 1'b0;
        rxd_out <= 4'h0;
        crs_out <= 1'b0;
      end else if (loopback_q) begin
        rx_dv_out <= tx_en_in && dead_cnt_q == 14'h0000;
        rxd_out <= txd_in;
        crs_out <= tx_en_in;
      end else begin
        rx_dv_out <= media_rx_dv_in;
        rxd_out <= media_rxd_in;
        crs_out <= media_crs_in;
      end
      if (coltest_q) begin
        col_out <= tx_en_in;
      end else begin
        col_out <= media_col_in & ~loopback_q & ~isolate_q & ~pd_eff;
      end
    end
  end

  property p_soft_reset_ends;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      $rose(soft_rst_q) |-> soft_rst_q[*8] ##[1:30] !soft_rst_q;
  endproperty
  a_soft_reset_ends: assert property (p_soft_reset_ends) else $error("soft reset did not end in time");

  property p_restrap;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      rst_done |=> speed_q == $past(strap_speed_100_in) && duplex_q == $past(strap_full_duplex_in);
  endproperty
  a_restrap: assert property (p_restrap) else $error("soft reset did not reload straps");

  property p_loopback_path;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      loopback_q && !isolate_q && !pd_eff |=> rxd_out == $past(txd_in);
  endproperty
  a_loopback_path: assert property (p_loopback_path) else $error("loopback data not returned");

  property p_dead_time;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      loopback_q && dead_cnt_q != 14'h0000 |=> !rx_dv_out;
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("receive valid during loopback dead time");

  property p_fiber_an_off;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      strap_load_q && fiber_mode_enable_in |=> !an_en_q;
  endproperty
  a_fiber_an_off: assert property (p_fiber_an_off) else $error("fiber mode left negotiation on");

  property p_forced_mode;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      !an_en_q |=> speed_100_out == $past(speed_q) && full_duplex_out == $past(duplex_q);
  endproperty
  a_forced_mode: assert property (p_forced_mode) else $error("forced mode not applied");

  property p_an_mode;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      an_en_q |=> speed_100_out == $past(an_speed_100_in) && full_duplex_out == $past(an_full_duplex_in);
  endproperty
  a_an_mode: assert property (p_an_mode) else $error("forced bits used during negotiation");

  property p_power_or;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      !external_power_down_pin_n_in |=> pwrdn_q ##1 power_down_out;
  endproperty
  a_power_or: assert property (p_power_or) else $error("pin did not set power down");

  property p_restart_ignored;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      ctl_wr && !wr_data[pbm_pkg::CTL_AN_ENABLE] |=> !restart_q ##1 !an_restart_out;
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("restart taken while negotiation off");

  property p_col_test;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      coltest_q && $changed(tx_en_in) |=> col_out == $past(tx_en_in);
  endproperty
  a_col_test: assert property (p_col_test) else $error("collision test COL late");

  property p_isolate;
    @(posedge clock_in) disable iff (!arst_n_in || !ce_in)
      isolate_q |=> !mii_oe_out && !rx_dv_out;
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolated port still drives MII");
endmodule : pbm_basic_mode_control
`default_nettype wire

// file: testbench/pbm_mgmt_model.sv
// Management station model that runs read and write frames
`default_nettype none
module pbm_mgmt_model (
  // Clock
  input wire logic clock_in,
  // Management pins
  output logic mdc_out,
  output logic mdio_drv_out,
  output logic mdio_oe_out,
  input wire logic mdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc_out = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_oe_out = 1'b0;
  end
  // Three clocks per half period; the slave needs one; clock stands low between frames
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rdat);
    logic [33:0] bits;
    bits = {2'h3, 2'h1, (rd ? 2'h2 : 2'h1), 5'h03, ra, 2'h2, wd};
    rdat = 16'h0000;
    for (int i = 0; i < 35; i++) begin
      mdio_oe_out <= (i < 34) && !(rd && i >= 16);
      mdio_drv_out <= (i < 34) ? bits[33 - i] : 1'b1;
      repeat (3) @(posedge clock_in);
      mdc_out <= 1'b1;
      if (rd && i >= 18 && i < 34) begin
        rdat = {rdat[14:0], mdio_in};
      end
      repeat (3) @(posedge clock_in);
      mdc_out <= 1'b0;
    end
  endtask : frame
endmodule : pbm_mgmt_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the basic mode control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, arst_n_in, mdc, mdio_w, m_d, m_oe, d_out, d_oe, aux;
  logic sp, fd, ane, fib, pd_n, an_st, an_sp, an_fd, link, rxe, tx_en;
  logic rx_dv, crs, col, mii_oe, m_tx_en, p_rst, pd, spd, dup, an_en, an_rs;
  logic [3:0] txd, rxd, m_txd;
  int bad_count, cmp_count;
  localparam int DEAD = 20;
  // Pull-up on the shared data line
  assign mdio_w = d_oe ? d_out : (m_oe ? m_d : 1'b1);
  pbm_basic_mode_control #(.LOOPBACK_DEAD_CYCLES(DEAD)) u_pbm_basic_mode_control (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .mdc_in(mdc), .mdio_in(mdio_w),
    .mdio_out(d_out), .mdio_oe_out(d_oe), .strap_phy_addr_in(5'h03), .strap_speed_100_in(sp),
    .strap_full_duplex_in(fd), .strap_an_enable_in(ane), .fiber_mode_enable_in(fib),
    .external_power_down_pin_n_in(pd_n), .an_started_in(an_st), .an_speed_100_in(an_sp),
    .an_full_duplex_in(an_fd), .an_complete_in(aux), .link_up_in(link), .remote_fault_in(aux),
    .jabber_in(aux), .rx_error_in(rxe), .tx_en_in(tx_en), .txd_in(txd), .media_rx_dv_in(aux),
    .media_rxd_in({4{aux}}), .media_crs_in(aux), .media_col_in(aux), .rx_dv_out(rx_dv), .rxd_out(rxd),
    .crs_out(crs), .col_out(col), .mii_oe_out(mii_oe), .media_tx_en_out(m_tx_en), .media_txd_out(m_txd),
    .port_reset_out(p_rst), .power_down_out(pd), .speed_100_out(spd), .full_duplex_out(dup),
    .an_enable_out(an_en), .an_restart_out(an_rs));
  pbm_mgmt_model u_pbm_mgmt_model (.clock_in(clock_in), .mdc_out(mdc), .mdio_drv_out(m_d),
    .mdio_oe_out(m_oe), .mdio_in(mdio_w));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bit_chk(input logic s, input logic e);
    check({15'h0000, s}, {15'h0000, e});
  endtask : bit_chk
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] t;
    u_pbm_mgmt_model.frame(1'b0, a, d, t);
  endtask : wr
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] t;
    u_pbm_mgmt_model.frame(1'b1, a, 16'h0000, t);
    check(t, e);
  endtask : rd_chk
  task automatic t_modes();
    rd_chk(5'h00, 16'h3100);
    wr(5'h00, 16'h217f);
    rd_chk(5'h00, 16'h2100);
    bit_chk(spd, 1'b1);
    bit_chk(dup, 1'b1);
    wr(5'h00, 16'h0000);
    bit_chk(spd, 1'b0);
    bit_chk(dup, 1'b0);
    an_sp <= 1'b1;
    an_fd <= 1'b1;
    wr(5'h00, 16'h1000);
    bit_chk(spd, 1'b1);
    bit_chk(dup, 1'b1);
  endtask : t_modes
  task automatic t_restart();
    wr(5'h00, 16'h1200);
    bit_chk(an_rs, 1'b1);
    wr(5'h00, 16'h1000);
    rd_chk(5'h00, 16'h1200);
    an_st <= 1'b1;
    @(posedge clock_in);
    an_st <= 1'b0;
    rd_chk(5'h00, 16'h1000);
    wr(5'h00, 16'h0200);
    rd_chk(5'h00, 16'h0000);
  endtask : t_restart
  task automatic t_power_col();
    tx_en <= 1'b1;
    txd <= 4'ha;
    pd_n <= 1'b0;
    repeat (3) @(posedge clock_in);
    bit_chk(pd, 1'b1);
    check({12'h000, m_txd}, 16'h0000);
    bit_chk(m_tx_en, 1'b0);
    pd_n <= 1'b1;
    rd_chk(5'h00, 16'h0800);
    wr(5'h00, 16'h0080);
    check({12'h000, m_txd}, 16'h000a);
    bit_chk(m_tx_en, 1'b1);
    bit_chk(col, 1'b1);
    tx_en <= 1'b0;
    repeat (3) @(posedge clock_in);
    bit_chk(col, 1'b0);
  endtask : t_power_col
  task automatic t_loop();
    int n;
    tx_en <= 1'b1;
    txd <= 4'h5;
    wr(5'h00, 16'h4000);
    bit_chk(rx_dv, 1'b0);
    bit_chk(m_tx_en, 1'b0);
    check({12'h000, rxd}, 16'h0005);
    n = 0;
    while (rx_dv !== 1'b1 && n < 2 * DEAD) begin
      @(posedge clock_in);
      n++;
    end
    if (n == 2 * DEAD) begin
      bad_count++;
      give_verdict();
    end
    bit_chk(crs, 1'b1);
    tx_en <= 1'b0;
    aux <= 1'b1;
    wr(5'h00, 16'h0000);
    bit_chk(crs, 1'b1);
    wr(5'h00, 16'h0400);
    bit_chk(mii_oe, 1'b0);
    rd_chk(5'h00, 16'h0400);
    aux <= 1'b0;
  endtask : t_loop
  task automatic t_status_soft();
    link <= 1'b0;
    rxe <= 1'b1;
    repeat (3) @(posedge clock_in);
    rxe <= 1'b0;
    link <= 1'b1;
    rd_chk(5'h01, 16'h785a);
    rd_chk(5'h01, 16'h784c);
    rd_chk(5'h14, 16'h0003);
    rd_chk(5'h14, 16'h0000);
    fib <= 1'b1;
    wr(5'h00, 16'h8000);
    bit_chk(p_rst, 1'b1);
    rd_chk(5'h00, 16'h2100);
  endtask : t_status_soft
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    {arst_n_in, aux, an_st, an_sp, an_fd, fib, link, rxe, tx_en} = '0;
    {sp, fd, ane, pd_n} = 4'hf;
    txd = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    bit_chk(an_en, 1'b1);
    t_modes();
    t_restart();
    t_power_col();
    t_loop();
    t_status_soft();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
